// ==== src/csd_clock_synth.sv ====
/*
 * Digital model of a frequency synthesizer with post, secondary, divide-by-3
 * and phase/duty shifted outputs, a lock flag, and an edge clock divider.
 * All clock-like inputs are synchronous to clock and sampled for rising edges;
 * the system clock itself stands in for the oscillator. Registers sit on APB.
 */
// Local design decisions: the APB register port and the register addresses.
`default_nettype none

module csd_clock_synth (
    // System clock, reset and enable
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    // Register bus
    input wire csd_pkg::csd_apb_req_t apb_req,
    output csd_pkg::csd_apb_rsp_t apb_rsp,
    // Synthesizer inputs
    input wire logic reference_clock_in,
    input wire logic feedback_clock_in,
    input wire logic synth_reset,
    input wire logic secondary_divider_reset,
    input wire csd_pkg::csd_dyn_t dyn_adjust,
    // Synthesizer outputs
    output logic primary_clock_out,
    output logic secondary_divided_clock_out,
    output logic third_divided_clock_out,
    output logic shifted_clock_out,
    output logic locked,
    // Edge divider
    input wire logic edge_clock,
    input wire logic divider_reset,
    input wire logic divider_release,
    output logic edge_divided_clock_out
);
    import csd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    csd_div_cfg_t div_cfg_reg;
    csd_phase_cfg_t phase_cfg_reg;
    logic [3:0] dyn_phase_reg;
    logic [3:0] dyn_duty_reg;
    logic ref_prev_reg;
    logic fb_prev_reg;
    logic edge_prev_reg;
    logic prim_prev_reg;
    logic ps_prev_reg;
    logic fb_seen_reg;
    logic [7:0] lock_cnt_reg;
    logic released_reg;
    logic [15:0] ps_hist_reg;
    logic dly_prev_reg;
    logic [3:0] duty_cnt_reg;
    logic ref_rise, fb_ext_rise, edge_rise, prim_rise, fb_evt, edge_tick;
    logic ref_div_out, ref_div_rise, fb_div_out, fb_div_rise;
    logic ps_out, ps_rise;
    logic [3:0] act_phase, act_duty;
    logic dly;
    logic access, setup, mapped;
    logic [31:0] rd_word;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection of the sampled clock inputs and of the primary output
    assign ref_rise = reference_clock_in & ~ref_prev_reg;
    assign fb_ext_rise = feedback_clock_in & ~fb_prev_reg;
    assign edge_rise = edge_clock & ~edge_prev_reg;
    assign prim_rise = primary_clock_out & ~prim_prev_reg;

    always_ff @(posedge clock) begin
        if (srst) begin
            ref_prev_reg <= 1'b0;
            fb_prev_reg <= 1'b0;
            edge_prev_reg <= 1'b0;
            prim_prev_reg <= 1'b0;
        end else if (ce) begin
            ref_prev_reg <= reference_clock_in;
            fb_prev_reg <= feedback_clock_in;
            edge_prev_reg <= edge_clock;
            prim_prev_reg <= primary_clock_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input and feedback dividers
    // feedback source select
    assign fb_evt = phase_cfg_reg.fb_external ? fb_ext_rise : prim_rise;

    csd_div_unit u_in_div (
        .clock(clock), .srst(srst), .ce(ce), .hold(synth_reset),
        .tick(ref_rise), .ratio(div_cfg_reg.in_div),
        .div_out(ref_div_out), .rise(ref_div_rise)
    );

    csd_div_unit u_fb_div (
        .clock(clock), .srst(srst), .ce(ce), .hold(synth_reset),
        .tick(fb_evt), .ratio(div_cfg_reg.fb_div),
        .div_out(fb_div_out), .rise(fb_div_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Lock detection: every divided reference period must see a feedback edge.
    // Set of the seen flag wins over its clear so a coincident edge is kept.
    always_ff @(posedge clock) begin
        if (srst) begin
            fb_seen_reg <= 1'b0;
            lock_cnt_reg <= 8'h00;
            locked <= 1'b0;
        end else if (ce && synth_reset) begin
            fb_seen_reg <= 1'b0;
            lock_cnt_reg <= 8'h00;
            locked <= 1'b0;
        end else if (ce) begin
            fb_seen_reg <= fb_div_rise | (fb_seen_reg & ~ref_div_rise);
            if (ref_div_rise) begin
                if (!(fb_seen_reg | fb_div_rise)) begin
                    lock_cnt_reg <= 8'h00;
                    locked <= 1'b0;
                end else if (lock_cnt_reg < phase_cfg_reg.lock_len) begin
                    lock_cnt_reg <= lock_cnt_reg + 8'h01;
                end else begin
                    locked <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Post-scaler and outputs derived from it
    // post-scaler on every oscillator cycle
    csd_div_unit u_post_div (
        .clock(clock), .srst(srst), .ce(ce), .hold(synth_reset),
        .tick(1'b1), .ratio(div_cfg_reg.post_div),
        .div_out(ps_out), .rise(ps_rise)
    );

    csd_div_unit u_sec_div (
        .clock(clock), .srst(srst), .ce(ce),
        .hold(synth_reset | secondary_divider_reset),
        .tick(ps_rise), .ratio(div_cfg_reg.sec_div),
        .div_out(secondary_divided_clock_out), .rise()
    );

    csd_div_unit u_third_div (
        .clock(clock), .srst(srst), .ce(ce), .hold(synth_reset),
        .tick(prim_rise), .ratio(8'h03),
        .div_out(third_divided_clock_out), .rise()
    );

    // duty trim stretches high time by one cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            ps_prev_reg <= 1'b0;
            primary_clock_out <= 1'b0;
        end else if (ce) begin
            ps_prev_reg <= ps_out;
            primary_clock_out <= ps_out | (phase_cfg_reg.duty_trim & ps_prev_reg & ~synth_reset);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase and duty shifted output
    // dynamic values replace fixed ones when enabled
    assign act_phase = phase_cfg_reg.dyn_en ? dyn_phase_reg : phase_cfg_reg.phase;
    assign act_duty = phase_cfg_reg.dyn_en ? dyn_duty_reg : phase_cfg_reg.duty;
    assign dly = ps_hist_reg[act_phase];

    // fine delay strobe loads the user settings
    always_ff @(posedge clock) begin
        if (srst) begin
            dyn_phase_reg <= 4'h0;
            dyn_duty_reg <= 4'h0;
        end else if (ce && dyn_adjust.load) begin
            dyn_phase_reg <= dyn_adjust.phase;
            dyn_duty_reg <= dyn_adjust.duty;
        end
    end

    // delay line and duty stretch; duty 0 follows the delayed waveform
    always_ff @(posedge clock) begin
        if (srst) begin
            ps_hist_reg <= 16'h0000;
            dly_prev_reg <= 1'b0;
            duty_cnt_reg <= 4'h0;
            shifted_clock_out <= 1'b0;
        end else if (ce && synth_reset) begin
            ps_hist_reg <= 16'h0000;
            dly_prev_reg <= 1'b0;
            duty_cnt_reg <= 4'h0;
            shifted_clock_out <= 1'b0;
        end else if (ce) begin
            ps_hist_reg <= {ps_hist_reg[14:0], ps_out};
            dly_prev_reg <= dly;
            if (dly & ~dly_prev_reg) begin
                shifted_clock_out <= 1'b1;
                duty_cnt_reg <= act_duty;
            end else if (act_duty == 4'h0) begin
                shifted_clock_out <= dly;
            end else if (duty_cnt_reg != 4'h0) begin
                duty_cnt_reg <= duty_cnt_reg - 4'h1;
            end else begin
                shifted_clock_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge divider
    // input source select
    assign edge_tick = phase_cfg_reg.edge_src_pri ? prim_rise : edge_rise;

    // reset drops release, release restarts outputs
    always_ff @(posedge clock) begin
        if (srst) begin
            released_reg <= 1'b0;
        end else if (ce) begin
            if (divider_reset) begin
                released_reg <= 1'b0;
            end else if (divider_release) begin
                released_reg <= 1'b1;
            end
        end
    end

    // counter restarts on release so phase is repeatable
    csd_div_unit u_edge_div (
        .clock(clock), .srst(srst), .ce(ce),
        .hold(divider_reset | ~released_reg),
        .tick(edge_tick), .ratio(csd_edge_ratio(phase_cfg_reg.edge_mode)),
        .div_out(edge_divided_clock_out), .rise()
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: no wait states, pready raised in the first access cycle
    assign setup = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable;

    always_comb begin
        mapped = 1'b1;
        rd_word = 32'h0000_0000;
        if (apb_req.paddr == CSD_OFF_DIV) begin
            rd_word = div_cfg_reg;
        end else if (apb_req.paddr == CSD_OFF_PHASE) begin
            rd_word = phase_cfg_reg;
        end else if (apb_req.paddr == CSD_OFF_STATUS) begin
            rd_word[CSD_ST_LOCKED] = locked;
            rd_word[CSD_ST_RELEASED] = released_reg;
            rd_word[CSD_ST_PHASE_LSB +: 4] = act_phase;
            rd_word[CSD_ST_DUTY_LSB +: 4] = act_duty;
        end else begin
            mapped = 1'b0;
        end
    end

    // Response registers; read data is captured in the setup cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            apb_rsp <= '0;
        end else if (ce) begin
            apb_rsp.pready <= setup;
            apb_rsp.pslverr <= setup & ~mapped;
            apb_rsp.prdata <= (setup && !apb_req.pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // Writes land at the completing edge; status is read only
    always_ff @(posedge clock) begin
        if (srst) begin
            div_cfg_reg <= CSD_DIV_RST;
            phase_cfg_reg <= CSD_PHASE_RST;
        end else if (ce && access && apb_rsp.pready && apb_req.pwrite) begin
            if (apb_req.paddr == CSD_OFF_DIV) begin
                div_cfg_reg <= apb_req.pwdata;
            end else if (apb_req.paddr == CSD_OFF_PHASE) begin
                phase_cfg_reg <= apb_req.pwdata & CSD_PHASE_WMASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    AST_LOCK_CLEAR: assert property ((ce && synth_reset) |=> !locked)
        else $error("settled flag not cleared by synthesizer reset");
    AST_LOCK_RISE: assert property ($rose(locked) |-> $past(ref_div_rise) && $past(fb_seen_reg || fb_div_rise))
        else $error("settled flag rose without a matched reference period");
    AST_PRIM_HOLD: assert property ((ce && synth_reset) [*2] |=> !primary_clock_out)
        else $error("primary output not held low in synthesizer reset");
    AST_PRIM_SRC: assert property ($rose(primary_clock_out) |-> $past(ps_out))
        else $error("primary output rose without post-scaler");
    AST_SEC_HOLD: assert property ((ce && secondary_divider_reset) |=> !secondary_divided_clock_out)
        else $error("secondary output not held by its reset");
    AST_SEC_SRC: assert property ($rose(secondary_divided_clock_out) |-> $past(ps_rise))
        else $error("secondary output rose off a post-scaler edge");
    AST_THIRD_SRC: assert property ($rose(third_divided_clock_out) |-> $past(prim_rise))
        else $error("third output rose off a primary edge");
    AST_EDGE_HOLD: assert property ((ce && divider_reset) |=> !edge_divided_clock_out && !released_reg)
        else $error("edge output not forced low by divider reset");
    AST_EDGE_FIRST: assert property ((ce && released_reg && !divider_reset && edge_tick && !$past(released_reg))
        |=> edge_divided_clock_out)
        else $error("first counted edge after release did not rise");
    AST_EDGE_REL: assert property ($rose(edge_divided_clock_out) |-> $past(released_reg))
        else $error("edge output moved before release");

endmodule

`default_nettype wire

// ==== src/csd_pkg.sv ====
/*
 * Shared constants and types of the clock synthesizer and edge divider model:
 * register offsets, field layouts, reset values and the bus carriers.
 * Assumes a single 25 MHz system clock that samples every clock-like input.
 */
`default_nettype none

package csd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses on the APB)
    localparam logic [11:0] CSD_OFF_DIV = 12'h000;
    localparam logic [11:0] CSD_OFF_PHASE = 12'h004;
    localparam logic [11:0] CSD_OFF_STATUS = 12'h008;

    // Divider ratio register: secondary, post-scaler, feedback, input
    typedef struct packed {
        logic [7:0] sec_div;
        logic [7:0] post_div;
        logic [7:0] fb_div;
        logic [7:0] in_div;
    } csd_div_cfg_t;

    localparam csd_div_cfg_t CSD_DIV_RST = 32'h0202_0101;

    // Phase, duty and routing register
    typedef struct packed {
        logic [7:0] rsv1;
        logic [7:0] lock_len;
        logic [1:0] rsv0;
        logic edge_src_pri;
        logic duty_trim;
        logic fb_external;
        logic [1:0] edge_mode;
        logic dyn_en;
        logic [3:0] duty;
        logic [3:0] phase;
    } csd_phase_cfg_t;

    localparam csd_phase_cfg_t CSD_PHASE_RST = 32'h0010_0000;
    localparam logic [31:0] CSD_PHASE_WMASK = 32'h00FF_3FFF;

    // Status word field positions
    localparam int CSD_ST_LOCKED = 0;
    localparam int CSD_ST_RELEASED = 1;
    localparam int CSD_ST_PHASE_LSB = 4;
    localparam int CSD_ST_DUTY_LSB = 8;

    // Divider counter value that makes the next counted edge the first high one
    localparam logic [7:0] CSD_DIV_IDLE = 8'hFF;
    // Lowest edge-divider ratio; mode n selects this shifted left by n, at most by 2
    localparam logic [7:0] CSD_EDGE_BASE = 8'h02;
    localparam logic [1:0] CSD_EDGE_MODE_MAX = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Bus and adjust carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } csd_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } csd_apb_rsp_t;

    typedef struct packed {
        logic [3:0] phase;
        logic [3:0] duty;
        logic load;
    } csd_dyn_t;

    // Ratio of the edge divider for a mode code; code 3 behaves as divide by 8
    function automatic logic [7:0] csd_edge_ratio(input logic [1:0] mode);
        logic [1:0] m;
        m = (mode > CSD_EDGE_MODE_MAX) ? CSD_EDGE_MODE_MAX : mode;
        return CSD_EDGE_BASE << m;
    endfunction

endpackage

`default_nettype wire

// ==== src/csd_div_unit.sv ====
/*
 * Programmable event divider: counts tick pulses and makes a waveform that is
 * high for the first half of each period, plus a one-cycle rising pulse.
 * Assumes tick is a one-cycle pulse in the clock domain; ratio 0 acts as 1.
 */
`default_nettype none

module csd_div_unit (
    // Clock, reset and enable
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    // Control
    input wire logic hold,
    input wire logic tick,
    input wire logic [7:0] ratio,
    // Divided result
    output logic div_out,
    output logic rise
);
    import csd_pkg::*;

    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic [7:0] lim;
    logic [7:0] half;

    // Terminal count and the width of the high part, odd ratios round high up
    assign lim = (ratio == 8'h00) ? 8'h00 : ratio - 8'h01;
    assign half = (ratio == 8'h00) ? 8'h01 : 8'((({1'b0, ratio}) + 9'h001) >> 1);
    assign cnt_next = (cnt_reg >= lim) ? 8'h00 : cnt_reg + 8'h01;

    // Counter; a held unit restarts so that its first counted tick rises
    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_reg <= CSD_DIV_IDLE;
            div_out <= 1'b0;
            rise <= 1'b0;
        end else if (ce) begin
            rise <= 1'b0;
            if (hold) begin
                cnt_reg <= CSD_DIV_IDLE;
                div_out <= 1'b0;
            end else if (tick) begin
                cnt_reg <= cnt_next;
                div_out <= (cnt_next < half);
                rise <= (cnt_next == 8'h00);
            end
        end
    end

endmodule

`default_nettype wire

// ==== bench/csd_fabric_model.sv ====
/*
 * Fabric-side model of the clock net: returns the primary output to the
 * synthesizer as its external feedback clock, and can cut that path on command.
 * Assumes every signal is synchronous to the system clock.
 */
`default_nettype none

module csd_fabric_model (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Clock net from the synthesizer
    input wire logic primary_clock_out,
    // Scenario control
    input wire logic cut_feedback,
    // Feedback returned to the synthesizer
    output logic feedback_clock_in
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // feedback through clock net
    // One register models the net delay; a cut net stays low like a stopped clock
    always_ff @(posedge clock) begin
        if (srst || cut_feedback) begin
            feedback_clock_in <= 1'b0;
        end else begin
            feedback_clock_in <= primary_clock_out;
        end
    end
endmodule

`default_nettype wire

// ==== bench/csd_clock_synth_bench.sv ====
/*
 * Self-checking bench of the clock synthesizer: registers over APB, lock,
 * divided outputs, resets and the edge divider in modes 0 to 2.
 * Assumes the fabric model closes the external feedback path.
 */
`default_nettype none

module csd_clock_synth_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import csd_pkg::*;

    logic clock = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic reference_clock_in = 1'b0;
    logic edge_clock = 1'b0;
    logic edge_hold = 1'b0;
    logic synth_reset = 1'b0;
    logic secondary_divider_reset = 1'b0;
    logic divider_reset = 1'b0;
    logic divider_release = 1'b0;
    logic cut_feedback = 1'b0;
    csd_apb_req_t apb_req = '0;
    csd_apb_rsp_t apb_rsp;
    csd_dyn_t dyn_adjust = '0;
    logic feedback_clock_in, primary_clock_out, secondary_divided_clock_out;
    logic third_divided_clock_out, shifted_clock_out, locked, edge_divided_clock_out;
    logic [31:0] rd;
    logic er;
    int cnt [4];
    int num_errors = 0;
    int num_checks = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Clocks: system, reference and edge input (edge input can be stopped)
    initial forever #20 clock = ~clock;
    always @(posedge clock) begin
        reference_clock_in <= ~reference_clock_in;
        if (!edge_hold) begin
            edge_clock <= ~edge_clock;
        end
    end

    csd_clock_synth uut (
        .clock(clock), .srst(srst), .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .reference_clock_in(reference_clock_in), .feedback_clock_in(feedback_clock_in),
        .synth_reset(synth_reset), .secondary_divider_reset(secondary_divider_reset),
        .dyn_adjust(dyn_adjust), .primary_clock_out(primary_clock_out),
        .secondary_divided_clock_out(secondary_divided_clock_out),
        .third_divided_clock_out(third_divided_clock_out), .shifted_clock_out(shifted_clock_out),
        .locked(locked), .edge_clock(edge_clock), .divider_reset(divider_reset),
        .divider_release(divider_release), .edge_divided_clock_out(edge_divided_clock_out)
    );

    csd_fabric_model fabric (
        .clock(clock), .srst(srst), .primary_clock_out(primary_clock_out),
        .cut_feedback(cut_feedback), .feedback_clock_in(feedback_clock_in)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Reporting
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        num_errors++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            fail(msg);
        end
    endtask

    // Rise counts drift by one with the sampling phase, so allow that much
    task automatic near(input int got, input int exp, input string msg);
        num_checks++;
        if (got < exp - 1 || got > exp + 1) begin
            fail(msg);
        end
    endtask

    task automatic tmo();
        fail("wait ran out");
        end_sim();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // APB transfer: setup, access, hold until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (n > 20) tmo();
        end while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req <= '0;
    endtask

    // Rising edges of primary, secondary, third and shifted outputs over n cycles
    task automatic count(input int n);
        logic [3:0] prev, now;
        cnt = '{0, 0, 0, 0};
        @(posedge clock);
        prev = {shifted_clock_out, third_divided_clock_out, secondary_divided_clock_out, primary_clock_out};
        repeat (n) begin
            @(posedge clock);
            now = {shifted_clock_out, third_divided_clock_out, secondary_divided_clock_out, primary_clock_out};
            for (int i = 0; i < 4; i++) begin
                if (now[i] === 1'b1 && prev[i] === 1'b0) cnt[i]++;
            end
            prev = now;
        end
    endtask

    task automatic wait_lock(input logic v, input int lim);
        int n;
        n = 0;
        while (locked !== v) begin
            @(posedge clock);
            n++;
            if (n > lim) tmo();
        end
        num_checks++;
    endtask

    task automatic wait_edge(input logic v, output int n);
        n = 0;
        while (edge_divided_clock_out !== v) begin
            @(posedge clock);
            n++;
            if (n > 40) tmo();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Edge divider: reset holds low, release restarts, high and low last ratio
    task automatic edge_run(input logic [1:0] mode, input logic src_pri);
        int n, r;
        r = 2 << mode;
        edge_hold <= src_pri;
        apb(1'b1, CSD_OFF_PHASE, 32'h0001_0800 | (32'(src_pri) << 13) | (32'(mode) << 9));
        divider_reset <= 1'b1;
        repeat (3) @(posedge clock);
        chk(32'(edge_divided_clock_out), 32'h0, "edge output not low in reset");
        divider_reset <= 1'b0;
        divider_release <= 1'b1;
        @(posedge clock);
        divider_release <= 1'b0;
        wait_edge(1'b1, n);
        chk(32'(n <= 4), 32'h1, "first edge output rise late");
        wait_edge(1'b0, n);
        chk(32'(n), 32'(r), "edge output high time");
        wait_edge(1'b1, n);
        chk(32'(n), 32'(r), "edge output low time");
        apb(1'b0, CSD_OFF_STATUS, 32'h0);
        chk(32'(rd[1]), 32'h1, "release not reported");
        edge_hold <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        apb(1'b0, CSD_OFF_DIV, 32'h0);
        chk(rd, CSD_DIV_RST, "divider reset value");
        apb(1'b0, CSD_OFF_PHASE, 32'h0);
        chk(rd, CSD_PHASE_RST, "phase reset value");
        apb(1'b0, 12'h00C, 32'h0);
        chk({rd[30:0], er}, 32'h1, "unmapped read not refused");
        apb(1'b1, CSD_OFF_PHASE, 32'hFFFF_FFFF);
        apb(1'b0, CSD_OFF_PHASE, 32'h0);
        chk(rd, 32'h00FF_3FFF, "phase writable bits");
        apb(1'b1, CSD_OFF_DIV, 32'h0302_0101);
        apb(1'b0, CSD_OFF_DIV, 32'h0);
        chk(rd, 32'h0302_0101, "divider readback");
        apb(1'b1, CSD_OFF_PHASE, 32'h0001_0800);
        wait_lock(1'b1, 300);
        cut_feedback <= 1'b1;
        wait_lock(1'b0, 40);
        cut_feedback <= 1'b0;
        wait_lock(1'b1, 300);
        count(60);
        near(cnt[0], 30, "primary rate");
        near(cnt[1], 10, "secondary rate");
        near(cnt[2], 10, "third output rate");
        near(cnt[3], 30, "shifted rate");
        secondary_divider_reset <= 1'b1;
        count(60);
        chk(32'(cnt[1]), 32'h0, "secondary ran in its reset");
        near(cnt[0], 30, "primary stopped by secondary reset");
        chk(32'(locked), 32'h1, "lock lost by secondary reset");
        secondary_divider_reset <= 1'b0;
        // Enable low freezes every output and the settled flag
        ce <= 1'b0;
        count(20);
        chk(32'(cnt[0] + cnt[2] + cnt[3]), 32'h0, "outputs ran with enable low");
        chk(32'(locked), 32'h1, "lock lost while frozen");
        ce <= 1'b1;
        synth_reset <= 1'b1;
        repeat (2) @(posedge clock);
        chk(32'(locked), 32'h0, "lock kept in synthesizer reset");
        count(20);
        chk(32'(cnt[0] + cnt[1] + cnt[2] + cnt[3]), 32'h0, "outputs ran in reset");
        synth_reset <= 1'b0;
        wait_lock(1'b1, 300);
        apb(1'b1, CSD_OFF_PHASE, 32'h0001_0900);
        dyn_adjust <= '{phase: 4'h3, duty: 4'h2, load: 1'b1};
        @(posedge clock);
        dyn_adjust.load <= 1'b0;
        apb(1'b0, CSD_OFF_STATUS, 32'h0);
        chk({24'h0, rd[11:4]}, 32'h23, "dynamic phase and duty");
        for (int m = 0; m < 3; m++) begin
            edge_run(2'(m), 1'b0);
        end
        edge_run(2'h1, 1'b1);
        end_sim();
    end
endmodule

`default_nettype wire
